// [clcp_pkg.sv]
// package for the control list current pointer block
// assumes a single 40 MHz clock domain and a plain register port
package clcp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CLCP_CUR_OFFSET  = 8'h24; // current pointer reg
  localparam logic [7:0]  CLCP_CTRL_OFFSET = 8'h30; // local control reg
  localparam logic [7:0]  CLCP_STAT_OFFSET = 8'h34; // local status reg
  localparam logic [31:0] CLCP_CUR_RESET   = 32'h0000_0000;
  localparam int          CLCP_PTR_LSB     = 4;     // pointer field low bit
  localparam int          CLCP_PTR_W       = 28;    // pointer field width
  localparam int          CLCP_CLE_BIT     = 4;     // control list enable
  localparam int          CLCP_CLF_BIT     = 1;     // control list filled
  localparam logic [27:0] CLCP_END_OF_LIST = 28'h000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } clcp_bus_s;

  typedef struct packed {
    logic        served;  // descriptor done, next pointer valid
    logic        frame;   // start of frame
    logic [27:0] next;    // next descriptor link from memory
  } clcp_eng_s;

  typedef enum logic [1:0] {
    CLCP_IDLE = 2'b00,
    CLCP_WALK = 2'b01,
    CLCP_END  = 2'b10
  } clcp_state_e;

endpackage : clcp_pkg

// [clcp_decode.sv]
// register port decoder for the control list current pointer block
// assumes strobes are single cycle and never both high together
`timescale 1ns/1ps
module clcp_decode
  import clcp_pkg::*;
(
  input  wire clcp_bus_s bus_in,
  output logic           cur_wr_out,
  output logic           cur_rd_out,
  output logic           ctrl_wr_out,
  output logic           ctrl_rd_out,
  output logic           stat_rd_out,
  output logic           miss_rd_out
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // one hit per offset, unmapped reads flagged so they return zero
  wire hit_cur  = (bus_in.addr == CLCP_CUR_OFFSET);
  wire hit_ctrl = (bus_in.addr == CLCP_CTRL_OFFSET);
  wire hit_stat = (bus_in.addr == CLCP_STAT_OFFSET);

  assign cur_wr_out  = bus_in.wr & hit_cur;
  assign cur_rd_out  = bus_in.rd & hit_cur;
  assign ctrl_wr_out = bus_in.wr & hit_ctrl;
  assign ctrl_rd_out = bus_in.rd & hit_ctrl;
  assign stat_rd_out = bus_in.rd & hit_stat;
  assign miss_rd_out = bus_in.rd & ~(hit_cur | hit_ctrl | hit_stat);

endmodule : clcp_decode

// [clcp_top.sv]
// control list current pointer register and its list walk
// assumes engine strobes and register strobes are synchronous to SYS_CLK_IN
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module clcp_top
  import clcp_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        ENG_SERVED_IN,
  input  wire logic        ENG_FRAME_IN,
  input  wire logic [27:0] ENG_NEXT_IN,
  input  wire logic [27:0] HEAD_PTR_IN,
  input  wire logic        FILLED_SET_IN,
  output logic [31:0]      REG_RDATA_OUT,
  output logic [31:0]      CUR_PTR_OUT,
  output logic             FILLED_OUT,
  output logic             CLE_OUT,
  output logic             LIST_END_OUT
);

  // ----------------------------------------------------------------
  // carriers and decode
  // ----------------------------------------------------------------
  clcp_bus_s bus;
  clcp_eng_s eng;

  assign bus.wr    = REG_WR_IN;
  assign bus.rd    = REG_RD_IN;
  assign bus.addr  = REG_ADDR_IN;
  assign bus.wdata = REG_WDATA_IN;
  assign eng.served = ENG_SERVED_IN;
  assign eng.frame  = ENG_FRAME_IN;
  assign eng.next   = ENG_NEXT_IN;

  logic cur_wr;
  logic cur_rd;
  logic ctrl_wr;
  logic ctrl_rd;
  logic stat_rd;
  logic miss_rd;

  clcp_decode u_decode (
    .bus_in      (bus),
    .cur_wr_out  (cur_wr),
    .cur_rd_out  (cur_rd),
    .ctrl_wr_out (ctrl_wr),
    .ctrl_rd_out (ctrl_rd),
    .stat_rd_out (stat_rd),
    .miss_rd_out (miss_rd)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [27:0] ptr_ff;
  logic [27:0] nxt_ptr;
  logic        cle_ff;
  logic        nxt_cle;
  logic        filled_ff;
  logic        nxt_filled;
  logic        end_ff;
  logic        nxt_end;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  clcp_state_e state_ff;
  clcp_state_e nxt_state;

  // ----------------------------------------------------------------
  // list walk
  // ----------------------------------------------------------------
  // walk only runs while enabled; a zero pointer marks the end
  wire at_end    = (ptr_ff == CLCP_END_OF_LIST);
  wire sw_wr_ok  = cur_wr & ~cle_ff;
  wire walk_end  = cle_ff & (state_ff == CLCP_END);
  wire reload    = walk_end & filled_ff;
  wire advance   = cle_ff & eng.served & ~at_end;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CLCP_IDLE: begin
        if (cle_ff) begin
          nxt_state = CLCP_WALK;
        end
      end
      CLCP_WALK: begin
        if (!cle_ff) begin
          nxt_state = CLCP_IDLE;
        end else if (at_end) begin
          nxt_state = CLCP_END;
        end
      end
      CLCP_END: begin
        // stay parked at end until reload, disable or a nonzero pointer
        if (!cle_ff) begin
          nxt_state = CLCP_IDLE;
        end else if (reload) begin
          nxt_state = CLCP_WALK;
        end else if (!at_end) begin
          nxt_state = CLCP_WALK;
        end
      end
    endcase
  end

  // pointer update: reload, advance, permitted write, else hold
  always_comb begin
    nxt_ptr = ptr_ff;
    if (reload) begin
      nxt_ptr = HEAD_PTR_IN;
    end else if (advance) begin
      nxt_ptr = eng.next;
    end else if (sw_wr_ok) begin
      nxt_ptr = bus.wdata[CLCP_PTR_LSB +: CLCP_PTR_W];
    end
  end

  // filled flag: hardware set wins over the reload clear
  assign nxt_filled = FILLED_SET_IN | (filled_ff & ~reload);
  assign nxt_cle    = ctrl_wr ? bus.wdata[CLCP_CLE_BIT] : cle_ff;
  assign nxt_end    = at_end;

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0] cur_word  = {ptr_ff, 4'h0};
  wire [31:0] ctrl_word = {27'h0, cle_ff, 4'h0};
  wire [31:0] stat_word = {29'h0, end_ff, filled_ff, 1'b0};

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (cur_rd) begin
      nxt_rdata = cur_word;
    end else if (ctrl_rd) begin
      nxt_rdata = ctrl_word;
    end else if (stat_rd) begin
      nxt_rdata = stat_word;
    end else if (miss_rd) begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // pointer clears to the end-of-list value on reset; end flag sets, the rest clear
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ptr_ff    <= CLCP_CUR_RESET[31:4];
      cle_ff    <= 1'b0;
      filled_ff <= 1'b0;
      end_ff    <= 1'b1;
      rdata_ff  <= 32'h0000_0000;
      state_ff  <= CLCP_IDLE;
    end else begin
      ptr_ff    <= nxt_ptr;
      cle_ff    <= nxt_cle;
      filled_ff <= nxt_filled;
      end_ff    <= nxt_end;
      rdata_ff  <= nxt_rdata;
      state_ff  <= nxt_state;
    end
  end

  // output flops, mirror of internal state
  logic [31:0] cur_out_ff;
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cur_out_ff <= CLCP_CUR_RESET;
    end else begin
      cur_out_ff <= {nxt_ptr, 4'h0};
    end
  end

  assign REG_RDATA_OUT = rdata_ff;
  assign CUR_PTR_OUT   = cur_out_ff;
  assign FILLED_OUT    = filled_ff;
  assign CLE_OUT       = cle_ff;
  assign LIST_END_OUT  = end_ff;

  // eng.frame needs no action: pointer is simply held across frames
  wire unused_frame = eng.frame;

endmodule : clcp_top

// [clcp_chk_sva.sv]
// checker on the ports of clcp_top
// assumes one clock domain; bound below
`timescale 1ns/1ps
module clcp_chk
  import clcp_pkg::*;
(
  input wire logic        SYS_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic        ENG_SERVED_IN,
  input wire logic        FILLED_SET_IN,
  input wire logic        FILLED_OUT,
  input wire logic        CLE_OUT,
  input wire logic        LIST_END_OUT,
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic [27:0] ENG_NEXT_IN,
  input wire logic [27:0] HEAD_PTR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic [31:0] CUR_PTR_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // end of list and pointer address decode
  wire z  = CUR_PTR_OUT == 32'h0;
  wire at = REG_ADDR_IN == CLCP_CUR_OFFSET;
  // list end met with the filled flag up
  sequence s_full;
    CLE_OUT && z && FILLED_OUT && !FILLED_SET_IN;
  endsequence
  a_reload_clears: assert property (s_full |-> ##[1:2] !FILLED_OUT)
    else $error("flag kept");
  a_reload_head: assert property ($fell(FILLED_OUT) |->
    CUR_PTR_OUT == {$past(HEAD_PTR_IN), 4'h0}) else $error("reload");
  a_idle_end: assert property (CLE_OUT && z && !FILLED_OUT &&
    !FILLED_SET_IN |=> z) else $error("moved at end");
  a_advance: assert property (ENG_SERVED_IN && CLE_OUT && !z |=>
    CUR_PTR_OUT == {$past(ENG_NEXT_IN), 4'h0}) else $error("advance");
  a_wr_locked: assert property (REG_WR_IN && at && CLE_OUT && !z &&
    !ENG_SERVED_IN |=> $stable(CUR_PTR_OUT)) else $error("locked");
  a_wr_load: assert property (REG_WR_IN && at && !CLE_OUT &&
    !FILLED_OUT |=> CUR_PTR_OUT == {$past(REG_WDATA_IN[31:4]), 4'h0})
    else $error("write");
  a_read_live: assert property (REG_RD_IN && at |=>
    REG_RDATA_OUT == $past(CUR_PTR_OUT)) else $error("read");
  a_end_flag: assert property (LIST_END_OUT == $past(z))
    else $error("end flag");
endmodule : clcp_chk
bind clcp_top clcp_chk u_chk (.*);

// [clcp_eng.sv]
// engine model: serves descriptors in turn, links count up to pointer 3 then list end
// assumes the pointer output of clcp_top and one clock
`timescale 1ns/1ps
module clcp_eng
  import clcp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic [31:0] cur_in,
  output logic             served_out,
  output logic [27:0]      next_out
);
  int         seed = 32'h1F;
  logic [1:0] gap_ff;
  wire        go = run_in && !served_out && |cur_in && gap_ff == 2'h0;
  // pulse after a random gap; a stale link is inverted, not held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {served_out, gap_ff, next_out} <= '0;
    end else begin
      served_out <= go;
      gap_ff     <= go ? 2'($random(seed)) : gap_ff - {1'b0, |gap_ff};
      next_out   <= !go ? ~next_out : cur_in[31:4] > 28'h2 ?
                    CLCP_END_OF_LIST : cur_in[31:4] + 28'h1;
    end
  end
endmodule : clcp_eng

// [testbench.sv]
// bench: clcp_top with engine model and bound checker
// assumes package, model and checker compile first
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  err_count++; $display("Error %s exp %h got %h", n, e, s); end end
module testbench;
  import clcp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, frm = 1'b0;
  logic        fs = 1'b0, run = 1'b0, sv, fl, le, ce;
  logic [7:0]  ad = 8'h0;
  logic [27:0] hd = 28'h0, nx;
  logic [31:0] wd = 32'h0, rdat, cur, d;
  int          err_count = 0, checked = 0, seed = 32'h9C28, i;
  clcp_top dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_ADDR_IN(ad), .REG_WDATA_IN(wd), .ENG_SERVED_IN(sv),
    .ENG_FRAME_IN(frm), .ENG_NEXT_IN(nx), .HEAD_PTR_IN(hd),
    .FILLED_SET_IN(fs), .REG_RDATA_OUT(rdat), .CUR_PTR_OUT(cur),
    .FILLED_OUT(fl), .CLE_OUT(ce), .LIST_END_OUT(le));
  clcp_eng eng (.clk_in(clk), .rst_in(rst), .run_in(run), .cur_in(cur),
    .served_out(sv), .next_out(nx));
  // clock
  initial forever #12.5 clk = ~clk;
  // wait for the n-th rising edge; drives that follow land on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one bus cycle; a read checks the data of the next cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge clk);
    {ad, wd} <= {a, v};
    {wr, rd} <= {w, !w};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1;
    if (!w) `CHK("read", v, rdat)
  endtask : bus
  // verdict
  task automatic close_out();
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // watchdog far past the expected run
  initial begin
    tick(2000);
    err_count++;
    close_out();
  end
  // main sequence
  initial begin
    tick(2);
    rst <= 1'b0;
    bus(1'b0, CLCP_CUR_OFFSET, 32'h0);
    bus(1'b0, 8'h50, 32'h0);
    for (i = 0; i < 4; i++) begin
      d = i ? $random(seed) : 32'hFFFF_FFFF;
      bus(1'b1, CLCP_CUR_OFFSET, d);
      bus(1'b0, CLCP_CUR_OFFSET, {d[31:4], 4'h0});
    end
    bus(1'b1, CLCP_CUR_OFFSET, 32'h1F);
    bus(1'b1, CLCP_CTRL_OFFSET, 32'h10);
    bus(1'b0, CLCP_CTRL_OFFSET, 32'h10);
    `CHK("enable", 1'b1, ce)
    bus(1'b1, CLCP_CUR_OFFSET, $random(seed));
    bus(1'b0, CLCP_CUR_OFFSET, 32'h10);
    tick(1);
    run <= 1'b1;
    for (i = 0; i < 40 && cur !== 32'h0; i++) tick(1);
    run <= 1'b0;
    hd  <= 28'($random(seed)) | 28'h10;
    tick(4);
    #1;
    `CHK("end", 33'h1_0000_0000, {le, cur})
    bus(1'b0, CLCP_STAT_OFFSET, 32'h0000_0004);
    tick(1);
    fs  <= 1'b1;
    tick(1);
    fs  <= 1'b0;
    for (i = 0; i < 8 && cur === 32'h0; i++) tick(1);
    #1;
    `CHK("reload", {1'b0, hd, 4'h0}, {fl, cur})
    tick(1);
    frm <= 1'b1;
    tick(1);
    frm <= 1'b0;
    #1;
    `CHK("frame", {hd, 4'h0}, cur)
    close_out();
  end
endmodule : testbench
